// [hw/dwd_map.svh]
// Register offset, field positions, reset value and timing counts of the watchdog.
// Assumes a single 100 MHz clock; included by the watchdog module only.
`ifndef DWD_MAP_SVH
`define DWD_MAP_SVH
`define DWD_REG_OFFSET 8'hd8
`define DWD_REG_RESET 8'hfe
`define DWD_BIT_ENABLE 0
`define DWD_BIT_TRIGGER 1
`define DWD_BIT_CNT_MSB 2
`define DWD_BIT_CNT_LSB 7
`define DWD_CLK_DIV 12
`define DWD_STEP_TICKS 256
`define DWD_MIN_PERIOD_OSC 3072
`define DWD_MAX_PERIOD_OSC 196608
`define DWD_GRACE_INSTR 28
`endif

// [hw/dwd_pkg.sv]
// Types shared by the watchdog design.
// Assumes nothing beyond the map header.
package dwd_pkg;
    typedef enum logic {DWD_MODE_SOFTWARE, DWD_MODE_HARDWARE} dwd_mode_t;
    typedef logic [6:0] dwd_count_t;
endpackage

// [hw/dwd_watchdog.sv]
// Digital watchdog downcounter with its data-space register.
// Assumes a synchronous register port from the core and an instruction-retire strobe.
`timescale 1ns/10ps
`include "dwd_map.svh"

// Behaviour
// RL1 - Counter reaching zero without reload raises system reset.
// RL2 - Software mode: inactive until software writes one to bit zero.
// RL3 - Once active, writes clearing the activation bit are ignored.
// RL4 - Hardware mode: activation bit reads one and cannot be changed.
// RL5 - Hardware mode: stop request acts as wait; counting continues.
// RL6 - Software mode and inactive: stop mode entry is permitted.
// RL7 - After stop exit by interrupt, counting resumes from held value.
// RL8 - Every reset loads register value fe.
// RL9 - Trigger bit becoming zero, by count or write, resets at once.
// RL10 - Register bit 7 is counter LSB, bit 2 count MSB.
// RL11 - Six count bits select 64 periods, 3072 to 196608 cycles.
// RL12 - Inactive watchdog is a free 7-bit timer that never resets.
// RL13 - At least 28 instructions run after activation before any reset.
// RL14 - Software reloads within 27 instructions, then regularly.
// RL15 - Software keeps trigger bit one when writing a count.
// RL16 - Prefer hardware activation unless stop mode is needed.
// RL17 - Watchdog reset reinitialises counter; restart as external reset.
// RL18 - Counter clocked from internal clock divided by 12.
// RL19 - Counter steps once per 256 divided ticks.
// RL20 - Register write loads counter at once, restarting countdown.
module dwd_watchdog #(
    parameter int STEP_TICKS = `DWD_STEP_TICKS,
    parameter int GRACE_INSTR = `DWD_GRACE_INSTR
) (
    // Clock and synchronous reset.
    input wire logic ref_clk,
    input wire logic rst,
    // Activation option, hardware or software.
    input wire logic hw_option,
    // Data-space register port.
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Core status.
    input wire logic instr_done,
    input wire logic stop_req,
    input wire logic stop_active,
    // Results.
    output logic wdg_reset,
    output logic stop_allowed,
    output logic wdg_active
);

    // ****************************************
    // Register state
    // ****************************************
    logic enable;
    dwd_pkg::dwd_count_t count;
    logic [3:0] div_cnt;
    logic div_tick;
    logic [7:0] step_cnt;
    logic [5:0] grace_cnt;
    logic act;
    logic hit;
    logic sel;
    logic [7:0] rd_view;
    dwd_pkg::dwd_count_t wr_count;

    // Address decode and the effective activation state.
    assign sel = (reg_addr == `DWD_REG_OFFSET);
    assign act = enable | hw_option; // RL4
    // Register bits 7..2 reversed onto count bits 0..5, trigger is count bit 6.
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            wr_count[i] = reg_wdata[`DWD_BIT_CNT_LSB - i]; // RL10
            rd_view[`DWD_BIT_CNT_LSB - i] = count[i];
        end
        wr_count[6] = reg_wdata[`DWD_BIT_TRIGGER];
        rd_view[`DWD_BIT_TRIGGER] = count[6];
        rd_view[`DWD_BIT_ENABLE] = act; // RL4
    end

    // ****************************************
    // Clock divider
    // ****************************************
    // Divides by 12; counting continues in wait and in hardware-mode stop.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            div_cnt <= 4'h0;
            div_tick <= 1'b0;
        end else if (stop_active && !hw_option) begin
            div_tick <= 1'b0; // RL7
        end else begin
            div_tick <= (div_cnt == 4'(`DWD_CLK_DIV - 1)); // RL18 RL5
            div_cnt <= (div_cnt == 4'(`DWD_CLK_DIV - 1)) ? 4'h0 : 4'(div_cnt + 4'h1);
        end
    end

    // Prescaler giving one counter step per STEP_TICKS divided ticks.
    // It wraps at the step length, so a shortened step divides correctly too.
    always_ff @(posedge ref_clk) begin
        if (rst || (reg_wr && sel)) begin
            step_cnt <= 8'h00;
        end else if (div_tick && step_cnt == 8'(STEP_TICKS - 1)) begin
            step_cnt <= 8'h00; // RL19
        end else if (div_tick) begin
            step_cnt <= 8'(step_cnt + 8'h01); // RL19
        end
    end

    // ****************************************
    // Activation and counter
    // ****************************************
    // Activation bit may only be set; reset alone clears it.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            enable <= 1'b0; // RL8
        end else if (reg_wr && sel && reg_wdata[`DWD_BIT_ENABLE]) begin
            enable <= 1'b1; // RL2 RL3
        end
    end

    // Counter loads on write and steps down; wraps freely as a timer.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            count <= 7'h7f; // RL8 RL17
        end else if (reg_wr && sel) begin
            count <= wr_count; // RL20 RL11
        end else if (div_tick && step_cnt == 8'(STEP_TICKS - 1)) begin
            count <= 7'(count - 7'h01); // RL12
        end
    end

    // Grace counter: instructions retired since activation.
    always_ff @(posedge ref_clk) begin
        if (rst || (!act)) begin
            grace_cnt <= 6'h00;
        end else if (instr_done && grace_cnt < 6'(GRACE_INSTR)) begin
            grace_cnt <= 6'(grace_cnt + 6'h01); // RL13
        end
    end

    // Trigger bit low while active requests reset after the grace window.
    assign hit = act && !count[6] && grace_cnt >= 6'(GRACE_INSTR); // RL1 RL9 RL12

    // ****************************************
    // Outputs
    // ****************************************
    // Registered outputs; the reset demand holds until the system reset arrives.
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            wdg_reset <= 1'b0;
            stop_allowed <= 1'b0;
            wdg_active <= 1'b0;
            reg_rdata <= 8'h00;
        end else begin
            wdg_reset <= wdg_reset | hit; // RL1 RL9 RL17
            stop_allowed <= !act; // RL6 RL5
            wdg_active <= act;
            reg_rdata <= (reg_rd && sel) ? rd_view : 8'h00;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    // Checks are cut off while reset is high, except the one that looks at its release.
    a_lock_enable: assert property (@(posedge ref_clk) disable iff (rst) $past(enable) |-> enable) // RL3
        else $error("Activation bit cleared without reset.");
    a_timer_silent: assert property (@(posedge ref_clk) disable iff (rst) !act |=> !wdg_reset) // RL12
        else $error("Inactive timer produced a reset.");
    a_reset_cause: assert property (@(posedge ref_clk) disable iff (rst) // RL1
        $rose(wdg_reset) |-> $past(act && !count[6] && grace_cnt >= 6'(GRACE_INSTR)))
        else $error("Reset without trigger bit low.");
    a_grace_hold: assert property (@(posedge ref_clk) disable iff (rst) grace_cnt < 6'(GRACE_INSTR) |=> !wdg_reset) // RL13
        else $error("Reset inside grace window.");
    a_write_load: assert property (@(posedge ref_clk) disable iff (rst) reg_wr && sel |=> count == $past(wr_count)) // RL20
        else $error("Write did not load counter.");
    a_stop_gate: assert property (@(posedge ref_clk) disable iff (rst) hw_option |=> !stop_allowed) // RL5
        else $error("Stop allowed in hardware mode.");
    a_stop_free: assert property (@(posedge ref_clk) disable iff (rst) !act ##1 !act |-> stop_allowed) // RL6
        else $error("Stop refused while inactive.");
    a_hold_stop: assert property (@(posedge ref_clk) disable iff (rst)
        stop_active && !hw_option && !(reg_wr && sel) ##1 !div_tick |=> $stable(count)) // RL7
        else $error("Counter moved in stop.");
    a_div_rate: assert property (@(posedge ref_clk) disable iff (rst) div_tick |=> !div_tick [*8]) // RL18
        else $error("Divider ticks too fast.");

    // Once raised, the reset demand stays until the system reset clears the block.
    a_reset_hold: assert property (@(posedge ref_clk) disable iff (rst) wdg_reset |=> wdg_reset) // RL1
        else $error("Reset demand dropped before system reset.");

    // The first clock after reset release sees the longest count and an idle watchdog.
    a_reset_value: assert property (@(posedge ref_clk) // RL8
        $fell(rst) |-> count == 7'h7f && !enable && grace_cnt == 6'h00)
        else $error("Reset state wrong after release.");

    // A write that clears the trigger bit after the grace window demands a reset.
    a_trigger_write: assert property (@(posedge ref_clk) disable iff (rst) // RL9
        act && grace_cnt >= 6'(GRACE_INSTR) && reg_wr && sel && !reg_wdata[`DWD_BIT_TRIGGER] |-> ##2 wdg_reset)
        else $error("Trigger write did not raise reset.");

    // Each step of the prescaler end moves the counter down by one.
    a_count_step: assert property (@(posedge ref_clk) disable iff (rst) // RL19
        div_tick && step_cnt == 8'(STEP_TICKS - 1) && !(reg_wr && sel) |=> count == 7'($past(count) - 7'h01))
        else $error("Counter did not step down.");

    // The prescaler never runs past the step length.
    a_step_range: assert property (@(posedge ref_clk) disable iff (rst) step_cnt <= 8'(STEP_TICKS - 1)) // RL19
        else $error("Prescaler beyond step length.");

    // In hardware mode a stop request leaves the divider running, as in wait.
    a_stop_wait: assert property (@(posedge ref_clk) disable iff (rst) // RL5
        hw_option && stop_req && stop_active && div_cnt == 4'h0 |=> div_cnt == 4'h1)
        else $error("Divider halted in hardware-mode stop.");

    // In hardware mode the activation bit always reads as one.
    a_hw_reads_one: assert property (@(posedge ref_clk) disable iff (rst) // RL4
        hw_option && reg_rd && sel |=> reg_rdata[`DWD_BIT_ENABLE])
        else $error("Activation bit read low in hardware mode.");

    // The trigger bit is read back as the top bit of the counter.
    a_read_trigger: assert property (@(posedge ref_clk) disable iff (rst) // RL12
        reg_rd && sel |=> reg_rdata[`DWD_BIT_TRIGGER] == $past(count[6]))
        else $error("Trigger bit read wrong.");

    // Register bit 7 is read back as the counter's lowest bit.
    a_read_lsb: assert property (@(posedge ref_clk) disable iff (rst) // RL10
        reg_rd && sel |=> reg_rdata[`DWD_BIT_CNT_LSB] == $past(count[0]))
        else $error("Counter low bit read wrong.");

    // The grace counter saturates at the window length.
    a_grace_limit: assert property (@(posedge ref_clk) disable iff (rst) grace_cnt <= 6'(GRACE_INSTR)) // RL13
        else $error("Grace counter overran.");
endmodule

// [verification/test_dwd_watchdog.sv]
// Self-checking bench for the watchdog downcounter, driven through its register port.
// Assumes the hw/ files are compiled first; steps shortened to 2 ticks, grace to 2 instructions.
`timescale 1ns/10ps
module test_dwd_watchdog;
    logic ref_clk, rst, hw_option, reg_wr, reg_rd, instr_done, stop_req, stop_active;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic wdg_reset, stop_allowed, wdg_active;
    int mismatches = 0;
    int comparisons = 0;
    int cycles = 0;
    // One counter step is 2 ticks of 12 clocks, so 24 clocks.
    dwd_watchdog #(.STEP_TICKS(2), .GRACE_INSTR(2)) u_dwd_watchdog (.ref_clk(ref_clk), .rst(rst),
        .hw_option(hw_option), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .instr_done(instr_done), .stop_req(stop_req), .stop_active(stop_active),
        .wdg_reset(wdg_reset), .stop_allowed(stop_allowed), .wdg_active(wdg_active));
    // ****************
    // Clock, timeout and shared tasks.
    // ****************
    initial begin
        ref_clk = 0;
        forever #5 ref_clk = ~ref_clk;
    end
    // A hang is cut short well beyond the expected run length.
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            conclude();
        end
    end
    task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge ref_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1;
        @(negedge ref_clk);
        reg_wr = 0;
    endtask
    task automatic rd(logic [7:0] exp);
        @(negedge ref_clk);
        reg_addr = 8'hd8;
        reg_rd = 1;
        @(negedge ref_clk);
        reg_rd = 0;
        check("register", reg_rdata, exp);
    endtask
    task automatic do_reset(logic hw);
        hw_option = hw;
        rst = 1;
        repeat (12) @(negedge ref_clk);
        rst = 0;
        repeat (2) @(negedge ref_clk);
    endtask
    task automatic instr(int n);
        repeat (n) begin
            @(negedge ref_clk);
            instr_done = 1;
            @(negedge ref_clk);
            instr_done = 0;
        end
    endtask
    task automatic wait_reset();
        repeat (40) if (wdg_reset !== 1'b1) @(negedge ref_clk);
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // ****************
    // Test sequence.
    // ****************
    initial begin
        {rst, hw_option, reg_wr, reg_rd, instr_done, stop_req, stop_active} = 7'h40;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        do_reset(0);
        rd(8'hfe);
        check("stop_allowed", 8'(stop_allowed), 8'h01);
        check("wdg_active", 8'(wdg_active), 8'h00);
        wr(8'hd8, 8'h02);
        wr(8'hd9, 8'h00);
        repeat (30) @(negedge ref_clk);
        rd(8'hfc);
        check("wdg_reset", 8'(wdg_reset), 8'h00);
        $display("test timer mode done");
        wr(8'hd8, 8'h03);
        wr(8'hd8, 8'h02);
        rd(8'h03);
        check("wdg_active", 8'(wdg_active), 8'h01);
        check("stop_allowed", 8'(stop_allowed), 8'h00);
        stop_active = 1;
        repeat (60) @(negedge ref_clk);
        rd(8'h03);
        stop_active = 0;
        instr(2);
        wait_reset();
        check("wdg_reset", 8'(wdg_reset), 8'h01);
        $display("test countdown reset done");
        do_reset(0);
        rd(8'hfe);
        wr(8'hd8, 8'h03);
        repeat (40) @(negedge ref_clk);
        check("wdg_reset", 8'(wdg_reset), 8'h00);
        instr(2);
        wait_reset();
        check("wdg_reset", 8'(wdg_reset), 8'h01);
        do_reset(0);
        wr(8'hd8, 8'h03);
        instr(2);
        wr(8'hd8, 8'h01);
        repeat (2) @(negedge ref_clk);
        check("wdg_reset", 8'(wdg_reset), 8'h01);
        $display("test grace and trigger write done");
        do_reset(1);
        rd(8'hff);
        check("wdg_active", 8'(wdg_active), 8'h01);
        wr(8'hd8, 8'h02);
        stop_req = 1;
        stop_active = 1;
        repeat (30) @(negedge ref_clk);
        rd(8'hfd);
        check("stop_allowed", 8'(stop_allowed), 8'h00);
        $display("test hardware option done");
        conclude();
    end
endmodule
